//--- logic/ocr_pkg.sv
// Package: register map, reset values, timing constants and carrier types for clock pin routing
package ocr_pkg;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned FS8K_PERIOD_NS = 125000;
    localparam int unsigned FS8K_PERIOD_CYC = FS8K_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned FS_PULSE_NS = 20;
    localparam int unsigned FS_PULSE_CYC_I = (FS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FRAMES_PER_MULTIFRAME = 4;
    localparam int unsigned CNT_W = 16;
    localparam logic [CNT_W-1:0] FS_PULSE_CYC = CNT_W'(FS_PULSE_CYC_I);

    localparam int unsigned NUM_CLK = 7;
    localparam int unsigned NUM_DIFF = 4;
    localparam int unsigned NUM_AUX = 5;
    localparam int unsigned NUM_GPIO = 3;
    localparam int unsigned FREQ_W = 20;

    // Byte offsets; frequency registers sit at FREQ_BASE + 4*n for clock n+1
    localparam logic [7:0] FREQ_BASE_OFS = 8'h00;
    localparam logic [7:0] DIFF_FORMAT_OFS = 8'h1c;
    localparam logic [7:0] AUX_ENABLE_OFS = 8'h20;
    localparam logic [7:0] FS_CTRL_OFS = 8'h24;
    localparam logic [7:0] STATUS_OFS = 8'h28;

    // Frequencies are held in kHz
    localparam logic [FREQ_W-1:0] FREQ_ONE_RST = 20'd6480;
    localparam logic [FREQ_W-1:0] FREQ_TWO_RST = 20'd38880;
    localparam logic [FREQ_W-1:0] FREQ_THREE_RST = 20'd19440;
    localparam logic [FREQ_W-1:0] FREQ_FOUR_RST = 20'd38880;
    localparam logic [FREQ_W-1:0] FREQ_FIVE_SDH_RST = 20'd2048;
    localparam logic [FREQ_W-1:0] FREQ_FIVE_SONET_RST = 20'd1544;
    localparam logic [FREQ_W-1:0] FREQ_SIX_RST = 20'd38880;
    localparam logic [FREQ_W-1:0] FREQ_SEVEN_RST = 20'd19440;

    localparam logic [1:0] FMT_DISABLED = 2'h0;
    localparam logic [1:0] FMT_LVDS = 2'h1;
    localparam logic [1:0] FMT_LVPECL = 2'h2;
    localparam logic [4:0] AUX_ENABLE_RST = 5'h00;
    localparam logic [3:0] FS_CTRL_RST = 4'h0;

    // Field positions
    localparam int unsigned FS8K_INV_BIT = 0;
    localparam int unsigned FS8K_PUL_BIT = 1;
    localparam int unsigned FS2K_INV_BIT = 2;
    localparam int unsigned FS2K_PUL_BIT = 3;
    localparam int unsigned ST_FAMILY_BIT = 0;
    localparam int unsigned ST_FS8K_BIT = 1;
    localparam int unsigned ST_FS2K_BIT = 2;
    localparam int unsigned STRAP_WAIT = 2;

    localparam logic [1:0] FAMILY_SDH = 2'h0;

    typedef logic [NUM_CLK-1:0][FREQ_W-1:0] ocr_freq_t;
    typedef logic [NUM_DIFF-1:0][1:0] ocr_fmt_t;

    typedef struct packed {
        logic [NUM_AUX-1:0] out;
        logic [NUM_AUX-1:0] oe;
    } ocr_aux_pin_t;

    typedef struct packed {
        ocr_freq_t freq;
        ocr_fmt_t fmt;
        logic [NUM_AUX-1:0] aux_en;
        logic [3:0] fs_ctrl;
        logic strap_sync1;
        logic strap_sync2;
        logic [1:0] strap_wait;
        logic strap_done;
        logic rate_family;
        logic [NUM_CLK-1:0] clk_sync1;
        logic [NUM_CLK-1:0] clk_sync2;
        logic [NUM_CLK-1:0] clk_pin;
        logic [NUM_GPIO-1:0] gpin_sync1;
        logic [NUM_GPIO-1:0] gpin_sync2;
        ocr_aux_pin_t aux;
        logic [CNT_W-1:0] cnt8;
        logic [1:0] frame_idx;
        logic fs8k;
        logic fs2k;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
    } ocr_state_t;
endpackage

//--- logic/ocr_pin_routing.sv
// Output clock pin routing, differential formats, auxiliary pins and frame-sync generation
`timescale 1ns/1ns
`default_nettype none
module ocr_pin_routing #(
    parameter logic [ocr_pkg::CNT_W-1:0] FS8K_PERIOD = ocr_pkg::CNT_W'(ocr_pkg::FS8K_PERIOD_CYC)
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [ocr_pkg::NUM_CLK-1:0] SYNTH_CLOCK_IN,
    output ocr_pkg::ocr_freq_t OUTPUT_FREQ_KHZ,
    output logic OUTPUT_CLOCK_ONE,
    output logic OUTPUT_CLOCK_TWO,
    output logic OUTPUT_CLOCK_THREE,
    output logic OUTPUT_CLOCK_FOUR,
    output logic OUTPUT_CLOCK_FIVE,
    output logic DIFF_CLOCK_FOUR_PLUS,
    output logic DIFF_CLOCK_FOUR_MINUS,
    output logic DIFF_CLOCK_FIVE_PLUS,
    output logic DIFF_CLOCK_FIVE_MINUS,
    output logic DIFF_CLOCK_SIX_PLUS,
    output logic DIFF_CLOCK_SIX_MINUS,
    output logic DIFF_CLOCK_SEVEN_PLUS,
    output logic DIFF_CLOCK_SEVEN_MINUS,
    output ocr_pkg::ocr_fmt_t DIFF_FORMAT,
    output ocr_pkg::ocr_aux_pin_t AUX_CLOCK_PIN,
    input wire logic [ocr_pkg::NUM_GPIO-1:0] AUX_CLOCK_PIN_IN,
    input wire logic [ocr_pkg::NUM_GPIO-1:0] GENERAL_IO_OUT,
    input wire logic [ocr_pkg::NUM_GPIO-1:0] GENERAL_IO_OE,
    output logic [ocr_pkg::NUM_GPIO-1:0] GENERAL_IO_IN,
    input wire logic RATE_FAMILY_STRAP,
    output logic RATE_FAMILY,
    output logic FRAME_SYNC_8K_OUT,
    output logic MULTIFRAME_SYNC_2K_OUT
);
    localparam logic [ocr_pkg::CNT_W-1:0] HALF8 = FS8K_PERIOD >> 1;
    localparam logic [1:0] LAST_FRAME = 2'(ocr_pkg::FRAMES_PER_MULTIFRAME - 1);
    localparam logic [1:0] HALF_FRAMES = 2'(ocr_pkg::FRAMES_PER_MULTIFRAME / 2);

    localparam ocr_pkg::ocr_state_t RESET_STATE = '{
        freq: {ocr_pkg::FREQ_SEVEN_RST, ocr_pkg::FREQ_SIX_RST, ocr_pkg::FREQ_FIVE_SDH_RST,
               ocr_pkg::FREQ_FOUR_RST, ocr_pkg::FREQ_THREE_RST, ocr_pkg::FREQ_TWO_RST,
               ocr_pkg::FREQ_ONE_RST},
        fmt: {4{ocr_pkg::FMT_LVDS}},
        aux_en: ocr_pkg::AUX_ENABLE_RST,
        fs_ctrl: ocr_pkg::FS_CTRL_RST,
        strap_sync1: 1'b0,
        strap_sync2: 1'b0,
        strap_wait: 2'h0,
        strap_done: 1'b0,
        rate_family: 1'b0,
        clk_sync1: '0,
        clk_sync2: '0,
        clk_pin: '0,
        gpin_sync1: '0,
        gpin_sync2: '0,
        aux: '0,
        cnt8: '0,
        frame_idx: 2'h0,
        fs8k: 1'b0,
        fs2k: 1'b0,
        dp_valid: 1'b0,
        dp_write: 1'b0,
        dp_addr: 8'h00
    };

    ocr_pkg::ocr_state_t s;
    ocr_pkg::ocr_state_t next_s;
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        for (int i = 0; i < ocr_pkg::NUM_CLK; i++) begin
            if (s.dp_addr == ocr_pkg::FREQ_BASE_OFS + 8'(4 * i)) begin
                rd_mux = {12'h000, s.freq[i]};
            end
        end
        case (s.dp_addr)
            ocr_pkg::DIFF_FORMAT_OFS: rd_mux = {24'h000000, s.fmt};
            ocr_pkg::AUX_ENABLE_OFS: rd_mux = {27'h0000000, s.aux_en};
            ocr_pkg::FS_CTRL_OFS: rd_mux = {28'h0000000, s.fs_ctrl};
            ocr_pkg::STATUS_OFS: rd_mux = {29'h00000000, s.fs2k, s.fs8k, s.rate_family};
            default: ;
        endcase
    end

    always_comb begin
        logic [ocr_pkg::CNT_W-1:0] in_frame;
        logic raw8;
        logic raw2;
        in_frame = '0;
        raw8 = 1'b0;
        raw2 = 1'b0;
        next_s = s;

        // Strap: two-flop synchroniser, then caught once the synchroniser holds a real pin value
        next_s.strap_sync1 = RATE_FAMILY_STRAP;
        next_s.strap_sync2 = s.strap_sync1;
        if (!s.strap_done) begin
            if (s.strap_wait == 2'(ocr_pkg::STRAP_WAIT)) begin
                next_s.strap_done = 1'b1;
                next_s.rate_family = s.strap_sync2;
                next_s.freq[4] = s.strap_sync2 ? ocr_pkg::FREQ_FIVE_SONET_RST
                                               : ocr_pkg::FREQ_FIVE_SDH_RST;
            end else begin
                next_s.strap_wait = s.strap_wait + 2'h1;
            end
        end

        // Synthesised clocks arrive from another domain and are resynchronised
        next_s.clk_sync1 = SYNTH_CLOCK_IN;
        next_s.clk_sync2 = s.clk_sync1;
        next_s.clk_pin = s.clk_sync2;
        next_s.gpin_sync1 = AUX_CLOCK_PIN_IN;
        next_s.gpin_sync2 = s.gpin_sync1;

        // Shared pins fall back to general I/O when their clock copy is disabled
        for (int i = 0; i < ocr_pkg::NUM_AUX; i++) begin
            if (s.aux_en[i]) begin
                next_s.aux.out[i] = s.clk_sync2[i];
                next_s.aux.oe[i] = 1'b1;
            end else if (i < ocr_pkg::NUM_GPIO) begin
                next_s.aux.out[i] = GENERAL_IO_OUT[i];
                next_s.aux.oe[i] = GENERAL_IO_OE[i];
            end else begin
                next_s.aux.out[i] = 1'b0;
                next_s.aux.oe[i] = 1'b0;
            end
        end

        // Multiframe is four 8 kHz frames, so both syncs stay phase aligned
        if (s.cnt8 >= FS8K_PERIOD - 1'b1) begin
            next_s.cnt8 = '0;
            next_s.frame_idx = (s.frame_idx == LAST_FRAME) ? 2'h0 : s.frame_idx + 2'h1;
        end else begin
            next_s.cnt8 = s.cnt8 + 1'b1;
        end
        in_frame = next_s.cnt8;
        if (next_s.fs_ctrl[ocr_pkg::FS8K_PUL_BIT]) begin
            raw8 = in_frame < ocr_pkg::FS_PULSE_CYC;
        end else begin
            raw8 = in_frame < HALF8;
        end
        if (next_s.fs_ctrl[ocr_pkg::FS2K_PUL_BIT]) begin
            raw2 = (next_s.frame_idx == 2'h0) && (in_frame < ocr_pkg::FS_PULSE_CYC);
        end else begin
            raw2 = next_s.frame_idx < HALF_FRAMES;
        end
        next_s.fs8k = raw8 ^ next_s.fs_ctrl[ocr_pkg::FS8K_INV_BIT];
        next_s.fs2k = raw2 ^ next_s.fs_ctrl[ocr_pkg::FS2K_INV_BIT];

        // AHB-Lite data phase write; reads are served from the live registers
        if (s.dp_valid && s.dp_write) begin
            for (int i = 0; i < ocr_pkg::NUM_CLK; i++) begin
                if (s.dp_addr == ocr_pkg::FREQ_BASE_OFS + 8'(4 * i)) begin
                    next_s.freq[i] = HWDATA[ocr_pkg::FREQ_W-1:0];
                end
            end
            case (s.dp_addr)
                ocr_pkg::DIFF_FORMAT_OFS: next_s.fmt = HWDATA[7:0];
                ocr_pkg::AUX_ENABLE_OFS: next_s.aux_en = HWDATA[ocr_pkg::NUM_AUX-1:0];
                ocr_pkg::FS_CTRL_OFS: next_s.fs_ctrl = HWDATA[3:0];
                default: ;
            endcase
        end
        if (HREADYOUT && HREADY) begin
            next_s.dp_valid = HSEL && HTRANS[1];
            next_s.dp_write = HWRITE;
            next_s.dp_addr = {HADDR[7:2], 2'b00};
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    // Wait states until the strap is caught keep early writes from being overwritten
    assign HREADYOUT = s.strap_done;
    assign HRESP = 1'b0;
    assign HRDATA = s.dp_valid ? rd_mux : 32'h0000_0000;
    assign OUTPUT_FREQ_KHZ = s.freq;
    assign OUTPUT_CLOCK_ONE = s.clk_pin[0];
    assign OUTPUT_CLOCK_TWO = s.clk_pin[1];
    assign OUTPUT_CLOCK_THREE = s.clk_pin[2];
    assign OUTPUT_CLOCK_FOUR = s.clk_pin[3];
    assign OUTPUT_CLOCK_FIVE = s.clk_pin[4];
    assign DIFF_CLOCK_FOUR_PLUS = s.clk_pin[3];
    assign DIFF_CLOCK_FOUR_MINUS = ~s.clk_pin[3];
    assign DIFF_CLOCK_FIVE_PLUS = s.clk_pin[4];
    assign DIFF_CLOCK_FIVE_MINUS = ~s.clk_pin[4];
    assign DIFF_CLOCK_SIX_PLUS = s.clk_pin[5];
    assign DIFF_CLOCK_SIX_MINUS = ~s.clk_pin[5];
    assign DIFF_CLOCK_SEVEN_PLUS = s.clk_pin[6];
    assign DIFF_CLOCK_SEVEN_MINUS = ~s.clk_pin[6];
    assign DIFF_FORMAT = s.fmt;
    assign AUX_CLOCK_PIN = s.aux;
    assign GENERAL_IO_IN = s.gpin_sync2;
    assign RATE_FAMILY = s.rate_family;
    assign FRAME_SYNC_8K_OUT = s.fs8k;
    assign MULTIFRAME_SYNC_2K_OUT = s.fs2k;
endmodule // ocr_pin_routing
`default_nettype wire

//--- tb/ocr_pin_routing_props.sv
// Checker: concurrent properties on the pin routing ports
`timescale 1ns/1ns
`default_nettype none
module ocr_pin_routing_props (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic HRESP,
    input wire logic [ocr_pkg::NUM_CLK-1:0] SYNTH_CLOCK_IN,
    input wire ocr_pkg::ocr_freq_t OUTPUT_FREQ_KHZ,
    input wire logic OUTPUT_CLOCK_ONE,
    input wire logic OUTPUT_CLOCK_TWO,
    input wire logic OUTPUT_CLOCK_THREE,
    input wire logic OUTPUT_CLOCK_FOUR,
    input wire logic OUTPUT_CLOCK_FIVE,
    input wire logic DIFF_CLOCK_FOUR_PLUS,
    input wire logic DIFF_CLOCK_FOUR_MINUS,
    input wire logic DIFF_CLOCK_FIVE_PLUS,
    input wire logic DIFF_CLOCK_FIVE_MINUS,
    input wire logic DIFF_CLOCK_SIX_PLUS,
    input wire logic DIFF_CLOCK_SIX_MINUS,
    input wire logic DIFF_CLOCK_SEVEN_PLUS,
    input wire logic DIFF_CLOCK_SEVEN_MINUS,
    input wire ocr_pkg::ocr_fmt_t DIFF_FORMAT,
    input wire ocr_pkg::ocr_aux_pin_t AUX_CLOCK_PIN,
    input wire logic FRAME_SYNC_8K_OUT,
    input wire logic MULTIFRAME_SYNC_2K_OUT
);
    logic [2:0] age;
    logic up;
    // Clock paths hold reset values for three edges, so history is trusted after that
    assign up = (age == 3'h4);
    always_ff @(posedge CLK) begin
        if (!RST_N) age <= 3'h0;
        else if (age != 3'h4) age <= age + 3'h1;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    clk_route_a: assert property (up |-> {OUTPUT_CLOCK_FIVE, OUTPUT_CLOCK_FOUR,
        OUTPUT_CLOCK_THREE, OUTPUT_CLOCK_TWO, OUTPUT_CLOCK_ONE} == $past(SYNTH_CLOCK_IN[4:0], 3))
        else $error("single ended clocks off their source");
    diff_four_a: assert property (DIFF_CLOCK_FOUR_PLUS == OUTPUT_CLOCK_FOUR
        && DIFF_CLOCK_FOUR_MINUS != DIFF_CLOCK_FOUR_PLUS) else $error("pair four wrong");
    diff_five_a: assert property (DIFF_CLOCK_FIVE_PLUS == OUTPUT_CLOCK_FIVE
        && DIFF_CLOCK_FIVE_MINUS != DIFF_CLOCK_FIVE_PLUS) else $error("pair five wrong");
    diff_six_a: assert property (up |-> DIFF_CLOCK_SIX_PLUS == $past(SYNTH_CLOCK_IN[5], 3)
        && DIFF_CLOCK_SIX_MINUS != DIFF_CLOCK_SIX_PLUS) else $error("pair six wrong");
    diff_seven_a: assert property (up |-> DIFF_CLOCK_SEVEN_PLUS == $past(SYNTH_CLOCK_IN[6], 3)
        && DIFF_CLOCK_SEVEN_MINUS != DIFF_CLOCK_SEVEN_PLUS) else $error("pair seven wrong");
    rst_freq_a: assert property ($rose(RST_N) |-> OUTPUT_FREQ_KHZ[3:0] == {20'h097e0,
        20'h04bf0, 20'h097e0, 20'h01950} && OUTPUT_FREQ_KHZ[6:5] == {20'h04bf0, 20'h097e0})
        else $error("frequency defaults wrong");
    rst_fmt_a: assert property ($rose(RST_N) |-> DIFF_FORMAT == 8'h55
        && AUX_CLOCK_PIN.oe == 5'h00) else $error("format or aux defaults wrong");
    // A driven aux pin four or five must copy its clock; an undriven one must stay low
    aux_idle_a: assert property (((AUX_CLOCK_PIN.out[4:3] & ~AUX_CLOCK_PIN.oe[4:3])
        | (AUX_CLOCK_PIN.oe[4:3] & (AUX_CLOCK_PIN.out[4:3]
        ^ {OUTPUT_CLOCK_FIVE, OUTPUT_CLOCK_FOUR}))) == 2'h0)
        else $error("aux pin four or five off its clock");
    okay_resp_a: assert property (HRESP == 1'b0) else $error("slave response not okay");
    sync_start_a: assert property ($rose(RST_N) |=> FRAME_SYNC_8K_OUT
        && MULTIFRAME_SYNC_2K_OUT) else $error("syncs not high at frame start");
    cover property ($rose(FRAME_SYNC_8K_OUT) ##1 $fell(FRAME_SYNC_8K_OUT));
    cover property ($rose(MULTIFRAME_SYNC_2K_OUT));
    cover property (AUX_CLOCK_PIN.oe == 5'h1f);
endmodule // ocr_pin_routing_props
bind ocr_pin_routing ocr_pin_routing_props u_props (.CLK, .RST_N, .HRESP, .SYNTH_CLOCK_IN,
    .OUTPUT_FREQ_KHZ, .OUTPUT_CLOCK_ONE, .OUTPUT_CLOCK_TWO, .OUTPUT_CLOCK_THREE,
    .OUTPUT_CLOCK_FOUR, .OUTPUT_CLOCK_FIVE, .DIFF_CLOCK_FOUR_PLUS, .DIFF_CLOCK_FOUR_MINUS,
    .DIFF_CLOCK_FIVE_PLUS, .DIFF_CLOCK_FIVE_MINUS, .DIFF_CLOCK_SIX_PLUS, .DIFF_CLOCK_SIX_MINUS,
    .DIFF_CLOCK_SEVEN_PLUS, .DIFF_CLOCK_SEVEN_MINUS, .DIFF_FORMAT, .AUX_CLOCK_PIN,
    .FRAME_SYNC_8K_OUT, .MULTIFRAME_SYNC_2K_OUT);
`default_nettype wire

//--- tb/ocr_sync_sink.sv
// Downstream model: measures period and high time of a sync line
`timescale 1ns/1ns
`default_nettype none
module ocr_sync_sink (
    input wire logic clk,
    input wire logic sync_in,
    output logic [15:0] period,
    output logic [15:0] high_len
);
    logic last;
    logic [15:0] since;
    logic [15:0] run;
    initial begin
        {last, since, run, period, high_len} = '0;
    end
    always @(posedge clk) begin
        last <= sync_in;
        since <= (sync_in && !last) ? 16'h1 : since + 16'h1;
        if (sync_in && !last) period <= since;
        run <= sync_in ? run + 16'h1 : 16'h0;
        if (!sync_in && last) high_len <= run;
    end
endmodule // ocr_sync_sink
`default_nettype wire

//--- tb/output_clock_pin_routing_test.sv
// Testbench: register access, pin routing and sync shapes
`timescale 1ns/1ns
`default_nettype none
module output_clock_pin_routing_test;
    logic clk, rst_n, hsel, hwrite, strap;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [6:0] synth;
    logic [2:0] pin_in, gp_out, gp_oe;
    wire [31:0] hrdata;
    wire [2:0] gp_in;
    wire [7:0] dp;
    wire hready, fam, fs8, fs2, c1, c2, c3, c4, c5;
    ocr_pkg::ocr_freq_t freq;
    ocr_pkg::ocr_fmt_t fmt;
    ocr_pkg::ocr_aux_pin_t aux;
    logic [15:0] p8, h8, p2, h2;
    int error_cnt, check_count;
    ocr_pin_routing #(.FS8K_PERIOD(16'h28)) dut (.CLK(clk), .RST_N(rst_n), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(), .SYNTH_CLOCK_IN(synth),
        .OUTPUT_FREQ_KHZ(freq), .OUTPUT_CLOCK_ONE(c1), .OUTPUT_CLOCK_TWO(c2),
        .OUTPUT_CLOCK_THREE(c3), .OUTPUT_CLOCK_FOUR(c4), .OUTPUT_CLOCK_FIVE(c5),
        .DIFF_CLOCK_FOUR_PLUS(dp[7]), .DIFF_CLOCK_FOUR_MINUS(dp[6]),
        .DIFF_CLOCK_FIVE_PLUS(dp[5]), .DIFF_CLOCK_FIVE_MINUS(dp[4]),
        .DIFF_CLOCK_SIX_PLUS(dp[3]), .DIFF_CLOCK_SIX_MINUS(dp[2]),
        .DIFF_CLOCK_SEVEN_PLUS(dp[1]), .DIFF_CLOCK_SEVEN_MINUS(dp[0]), .DIFF_FORMAT(fmt),
        .AUX_CLOCK_PIN(aux), .AUX_CLOCK_PIN_IN(pin_in), .GENERAL_IO_OUT(gp_out),
        .GENERAL_IO_OE(gp_oe), .GENERAL_IO_IN(gp_in), .RATE_FAMILY_STRAP(strap),
        .RATE_FAMILY(fam), .FRAME_SYNC_8K_OUT(fs8), .MULTIFRAME_SYNC_2K_OUT(fs2));
    ocr_sync_sink sink8 (.clk(clk), .sync_in(fs8), .period(p8), .high_len(h8));
    ocr_sync_sink sink2 (.clk(clk), .sync_in(fs2), .period(p2), .high_len(h2));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d, checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Bounded so a stuck ready ends the run instead of hanging it
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic t_defaults;
        logic [19:0] ef [7];
        ef = '{20'h01950, 20'h097e0, 20'h04bf0, 20'h097e0, 20'h00800, 20'h097e0, 20'h04bf0};
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, 8'(4 * i), 32'h0);
            chk(rd, ef[i]);
        end
        xfer(1'b1, 8'h2c, 32'hffff);
        xfer(1'b0, 8'h2c, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h55);
        chk(fam, 1'b0);
    endtask
    task automatic t_aux;
        synth <= 7'h55;
        gp_out <= 3'h4;
        gp_oe <= 3'h5;
        pin_in <= 3'h3;
        repeat (6) @(posedge clk);
        chk(aux, {5'h04, 5'h05});
        chk(gp_in, 3'h3);
        xfer(1'b1, 8'h20, 32'h1f);
        repeat (2) @(posedge clk);
        chk(aux, {5'h15, 5'h1f});
        synth <= 7'h2a;
        repeat (6) @(posedge clk);
        chk(aux, {5'h0a, 5'h1f});
        chk({c5, c4, c3, c2, c1}, 5'h0a);
        chk(dp, 8'h99);
    endtask
    task automatic t_diff;
        xfer(1'b1, 8'h1c, 32'hb4);
        xfer(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'hb4);
        chk(fmt, 8'hb4);
    endtask
    task automatic t_sync(input logic [3:0] ctl, input logic [63:0] exp);
        xfer(1'b1, 8'h24, {28'h0, ctl});
        // Two full multiframes after the change, so glitches at the switch are flushed
        repeat (360) @(posedge clk);
        chk({p8, h8, p2, h2}, exp);
    endtask
    task automatic t_strap;
        rst_n <= 1'b0;
        strap <= 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        xfer(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h608);
        chk(freq[4], 20'h00608);
        chk(fam, 1'b1);
        xfer(1'b0, 8'h28, 32'h0);
        chk(rd, 32'h7);
    endtask
    initial begin
        {rst_n, hsel, hwrite, strap, haddr, hwdata, htrans} = '0;
        {synth, pin_in, gp_out, gp_oe} = '0;
        error_cnt = 0;
        check_count = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_defaults();
        t_aux();
        t_diff();
        t_sync(4'h0, {16'h28, 16'h14, 16'ha0, 16'h50});
        t_sync(4'ha, {16'h28, 16'h01, 16'ha0, 16'h01});
        t_sync(4'hf, {16'h28, 16'h27, 16'ha0, 16'h9f});
        t_strap();
        report_and_stop();
    end
endmodule // output_clock_pin_routing_test
`default_nettype wire
